// ==== logic/xaui_rx_defines.svh ====
// named constants of the four-lane receive coding sublayer
// Function
// - data groups pass with control low; idle groups give 07, sequence 9C
// - any invalid code group comes out as FE with control high
// - deskew waits until all four lanes report synchronization
// - before its first /A/ a lane holds both deskew pointers still
// - after first /A/ the write pointer advances every word, read frozen
// - all four /A/ within 10 cycles releases all read pointers together
// - aligned flag rises after three more aligned /A/ columns
// - four misaligned /A/ columns with none aligned between drop alignment
// - sync after 4 commas, lost after 4 errors, 4 good cut one error
// - comma detection accepts a 7-bit or a 10-bit pattern
// - rate matching absorbs up to 200 ppm total clock difference
// - rate matching runs only with lanes synced and aligned
// - simultaneous /R/ columns are inserted or deleted to keep level
// - each deleted /R/ column pulses all four deleted flags one cycle
// - each inserted /R/ column pulses all four inserted flags one cycle
// - full drops the incoming column, empty adds nothing; flag held three cycles
`ifndef XAUI_RX_DEFINES_SVH
`define XAUI_RX_DEFINES_SVH
// ----------------------------------------------------------------
// code group values and receive characters
// ----------------------------------------------------------------
`define K28_0 8'h1C
`define K28_3 8'h7C
`define K28_4 8'h9C
`define K28_5 8'hBC
`define K27_7 8'hFB
`define K29_7 8'hFD
`define K30_7 8'hFE
`define XG_IDLE 8'h07
`define XG_SEQ 8'h9C
`define XG_START 8'hFB
`define XG_TERM 8'hFD
`define XG_ERR 8'hFE
// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define SYNC_ACQ 3'h4
`define SYNC_ERR 3'h4
`define SYNC_GOOD 3'h4
`define SKEW_WIN 4'hA
`define ALIGN_ACQ 2'h3
`define ALIGN_LOSS 3'h4
`define FLAG_HOLD 2'h3
`define RM_DEPTH 5'h10
`define RM_HI 5'hC
`define RM_LO 5'h4
`define RM_PPM 200
`endif

// ==== logic/xaui_rx_pkg.sv ====
// types shared by the receive coding sublayer
package xaui_rx_pkg;
	// one code group as delivered by the decoder of a lane
	typedef struct packed {
		logic [7:0] val;
		logic is_k;
		logic invalid;
		logic comma7;
		logic comma10;
	} lane_in_t;
	typedef struct packed {
		logic ctrl;
		logic [7:0] data;
	} xgmii_chr_t;
	typedef xgmii_chr_t [3:0] column_t;
	typedef struct packed {
		logic is_a;
		logic is_r;
		xgmii_chr_t chr;
	} lane_word_t;
	typedef enum {SYNC_LOSS, SYNC_COMMA, SYNC_OK} sync_state_t;
	typedef enum {DSK_IDLE, DSK_WAIT_A, DSK_CHECK, DSK_ALIGNED} deskew_state_t;
endpackage

// ==== logic/lane_sync.sv ====
// per-lane character mapping and synchronization state machine
`timescale 1ns/1ps
`include "xaui_rx_defines.svh"
module lane_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// code group and comma pattern length
	input wire xaui_rx_pkg::lane_in_t lane_i,
	input wire logic pattern_10_i,
	// mapped word and status
	output xaui_rx_pkg::lane_word_t word_o,
	output logic sync_o
);
	xaui_rx_pkg::sync_state_t state;
	logic [2:0] cnt;
	logic [2:0] good_cnt;
	logic comma;
	logic is_k_ok;

	function automatic xaui_rx_pkg::xgmii_chr_t map_chr(
		input xaui_rx_pkg::lane_in_t l);
		xaui_rx_pkg::xgmii_chr_t c;
		c.ctrl = 1'b1;
		c.data = `XG_ERR;
		if (!l.invalid && !l.is_k) begin
			c.ctrl = 1'b0;
			c.data = l.val;
		end else if (!l.invalid) begin
			case (l.val)
				`K28_0, `K28_3, `K28_5: c.data = `XG_IDLE;
				`K28_4: c.data = `XG_SEQ;
				`K27_7: c.data = `XG_START;
				`K29_7: c.data = `XG_TERM;
				default: c.data = `XG_ERR;
			endcase
		end
		return c;
	endfunction

	assign is_k_ok = lane_i.is_k && !lane_i.invalid;
	// pattern length selects which comma detector counts
	assign comma = is_k_ok && lane_i.val == `K28_5 &&
		(pattern_10_i ? lane_i.comma10 : lane_i.comma7);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			word_o <= '0;
		end else begin
			word_o.chr <= map_chr(lane_i);
			word_o.is_a <= is_k_ok && lane_i.val == `K28_3;
			word_o.is_r <= is_k_ok && lane_i.val == `K28_0;
		end
	end

	// cnt counts commas while acquiring and errors while in sync
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state <= xaui_rx_pkg::SYNC_LOSS;
			cnt <= 3'h0;
			good_cnt <= 3'h0;
			sync_o <= 1'b0;
		end else begin
			case (state)
				xaui_rx_pkg::SYNC_LOSS: begin
					cnt <= comma ? 3'h1 : 3'h0;
					if (comma) state <= xaui_rx_pkg::SYNC_COMMA;
				end
				xaui_rx_pkg::SYNC_COMMA: begin
					if (lane_i.invalid) begin
						state <= xaui_rx_pkg::SYNC_LOSS;
						cnt <= 3'h0;
					end else if (comma && 3'(cnt + 3'h1) == `SYNC_ACQ) begin
						state <= xaui_rx_pkg::SYNC_OK;
						sync_o <= 1'b1;
						cnt <= 3'h0;
						good_cnt <= 3'h0;
					end else if (comma) begin
						cnt <= 3'(cnt + 3'h1);
					end
				end
				xaui_rx_pkg::SYNC_OK: begin
					good_cnt <= 3'h0;
					if (lane_i.invalid && 3'(cnt + 3'h1) == `SYNC_ERR) begin
						state <= xaui_rx_pkg::SYNC_LOSS;
						sync_o <= 1'b0;
						cnt <= 3'h0;
					end else if (lane_i.invalid) begin
						cnt <= 3'(cnt + 3'h1);
					end else if (cnt != 3'h0) begin
						if (3'(good_cnt + 3'h1) == `SYNC_GOOD) begin
							cnt <= 3'(cnt - 3'h1);
						end else begin
							good_cnt <= 3'(good_cnt + 3'h1);
						end
					end
				end
				default: state <= xaui_rx_pkg::SYNC_LOSS;
			endcase
		end
	end

	sync_gain_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state == xaui_rx_pkg::SYNC_LOSS) ##0 comma[*4] |=> sync_o)
		else $error("sync not gained after four commas");
	sync_loss_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(sync_o && lane_i.invalid) ##1 lane_i.invalid[*3] |=> !sync_o)
		else $error("sync kept through four errors");
endmodule

// ==== logic/rate_match_fifo.sv ====
// column rate match buffer with /R/ insertion and deletion
`timescale 1ns/1ps
`include "xaui_rx_defines.svh"
module rate_match_fifo (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// aligned columns in
	input wire logic enable_i,
	input wire logic wr_valid_i,
	input wire xaui_rx_pkg::column_t col_i,
	input wire logic col_r_i,
	// local-rate drain
	input wire logic rd_en_i,
	output xaui_rx_pkg::column_t col_o,
	output logic col_valid_o,
	// status
	output logic [3:0] deleted_o,
	output logic [3:0] inserted_o,
	output logic full_o,
	output logic empty_o
);
	xaui_rx_pkg::column_t mem [16];
	logic [15:0] mem_r;
	logic [4:0] wptr, rptr, level;
	logic last_r, full, empty;
	logic do_del, do_wr, do_ins, do_rd, full_hit, empty_hit;
	logic [1:0] full_cnt, empty_cnt, full_nx, empty_nx;

	function automatic logic [1:0] hold_next(input logic hit,
		input logic [1:0] cnt);
		return hit ? `FLAG_HOLD : (cnt != 2'h0 ? 2'(cnt - 2'h1) : 2'h0);
	endfunction

	assign level = 5'(wptr - rptr);
	assign full = level == `RM_DEPTH;
	assign empty = level == 5'h0;
	// thresholds leave room for 200 ppm drift between /R/ gaps
	assign do_del = enable_i && wr_valid_i && col_r_i && level >= `RM_HI;
	assign do_wr = wr_valid_i && !do_del && !full;
	assign do_ins = enable_i && rd_en_i && last_r && level <= `RM_LO;
	assign do_rd = rd_en_i && !do_ins && !empty;
	// only /R/ columns are ever added or dropped on purpose
	assign full_hit = wr_valid_i && !do_del && full;
	assign empty_hit = rd_en_i && !do_ins && empty;
	assign full_nx = hold_next(full_hit, full_cnt);
	assign empty_nx = hold_next(empty_hit, empty_cnt);

	always_ff @(posedge clk_i) begin
		if (do_wr) begin
			mem[wptr[3:0]] <= col_i;
			mem_r[wptr[3:0]] <= col_r_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			wptr <= 5'h0;
			rptr <= 5'h0;
			last_r <= 1'b0;
			col_o <= '0;
			col_valid_o <= 1'b0;
		end else begin
			if (do_wr) wptr <= 5'(wptr + 5'h1);
			if (do_rd) begin
				rptr <= 5'(rptr + 5'h1);
				col_o <= mem[rptr[3:0]];
				last_r <= mem_r[rptr[3:0]];
			end
			col_valid_o <= do_rd || do_ins;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			deleted_o <= 4'h0;
			inserted_o <= 4'h0;
			full_cnt <= 2'h0;
			empty_cnt <= 2'h0;
			full_o <= 1'b0;
			empty_o <= 1'b0;
		end else begin
			deleted_o <= {4{do_del}};
			inserted_o <= {4{do_ins}};
			full_cnt <= full_nx;
			empty_cnt <= empty_nx;
			full_o <= full_nx != 2'h0;
			empty_o <= empty_nx != 2'h0;
		end
	end

	del_cause_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		deleted_o[0] |-> $past(enable_i && col_r_i && wr_valid_i))
		else $error("column deleted without an /R/ column");
	ins_cause_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		inserted_o[3] |-> $past(enable_i && rd_en_i) && col_valid_o)
		else $error("column inserted without a drain");
	full_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(full_o) |-> full_o[*3])
		else $error("full flag shorter than three cycles");
	empty_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(empty_o) |-> empty_o[*3])
		else $error("empty flag shorter than three cycles");
endmodule

// ==== logic/xaui_rx_deskew_rate_match.sv ====
// receive coding sublayer top: lane sync, deskew and rate match
`timescale 1ns/1ps
`include "xaui_rx_defines.svh"
module xaui_rx_deskew_rate_match (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// decoded code groups of the four lanes
	input wire xaui_rx_pkg::lane_in_t [3:0] lane_i,
	input wire logic pattern_10_i,
	// local-rate drain of the aligned stream
	input wire logic rm_rd_en_i,
	// aligned receive characters
	output xaui_rx_pkg::column_t rx_col_o,
	output logic rx_valid_o,
	// status
	output logic [3:0] lane_sync_o,
	output logic lanes_aligned_o,
	output logic [3:0] rm_deleted_o,
	output logic [3:0] rm_inserted_o,
	output logic rm_full_o,
	output logic rm_empty_o
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	xaui_rx_pkg::lane_word_t lw [4];
	xaui_rx_pkg::lane_word_t mem [4][16];
	xaui_rx_pkg::lane_word_t [3:0] dsk_col;
	xaui_rx_pkg::column_t dsk_chr;
	xaui_rx_pkg::deskew_state_t state;
	logic [3:0] wptr [4];
	logic [3:0] rptr [4];
	logic [3:0] a_seen;
	logic [3:0] a_in;
	logic [3:0] seen_now;
	logic [3:0] we;
	logic [3:0] col_a_v;
	logic [3:0] col_r_v;
	logic [3:0] win_cnt;
	logic [1:0] acq_cnt;
	logic [2:0] mis_cnt;
	logic dsk_valid;
	logic all_sync;
	logic in_wait;
	logic rd_run;
	logic release_rd;
	logic expire;
	logic col_aligned;
	logic col_mis;
	logic drop;
	logic restart;
	logic clear;
	logic col_r;

	// ----------------------------------------------------------------
	// lane mapping and synchronization
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 4; g++) begin : g_lane
		lane_sync u_lane (
			.clk_i(clk_i),
			.rst_b_i(rst_b_i),
			.lane_i(lane_i[g]),
			.pattern_10_i(pattern_10_i),
			.word_o(lw[g]),
			.sync_o(lane_sync_o[g])
		);
		assign a_in[g] = lw[g].is_a;
		assign col_a_v[g] = dsk_col[g].is_a;
		assign col_r_v[g] = dsk_col[g].is_r;
		assign dsk_chr[g] = dsk_col[g].chr;
	end

	// ----------------------------------------------------------------
	// deskew control terms
	// ----------------------------------------------------------------
	assign all_sync = &lane_sync_o;
	assign in_wait = state == xaui_rx_pkg::DSK_WAIT_A;
	assign rd_run = state == xaui_rx_pkg::DSK_CHECK ||
		state == xaui_rx_pkg::DSK_ALIGNED;
	assign seen_now = a_seen | a_in;
	// window counts from the cycle after the earliest /A/
	assign release_rd = in_wait && all_sync && &seen_now;
	assign expire = in_wait && |a_seen && !(&seen_now) &&
		4'(win_cnt + 4'h1) == `SKEW_WIN;
	assign col_aligned = dsk_valid && &col_a_v;
	assign col_mis = dsk_valid && |col_a_v && !(&col_a_v);
	assign drop = state == xaui_rx_pkg::DSK_ALIGNED && col_mis &&
		3'(mis_cnt + 3'h1) == `ALIGN_LOSS;
	// a misaligned column before the flag rises restarts acquisition
	assign restart = expire || drop ||
		(state == xaui_rx_pkg::DSK_CHECK && col_mis);
	assign clear = restart || !all_sync;
	assign col_r = dsk_valid && &col_r_v;

	always_comb begin
		for (int i = 0; i < 4; i++) begin
			we[i] = !clear && (rd_run || (in_wait && all_sync &&
				seen_now[i]));
		end
	end

	// ----------------------------------------------------------------
	// deskew state
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state <= xaui_rx_pkg::DSK_IDLE;
		end else if (!all_sync) begin
			state <= xaui_rx_pkg::DSK_IDLE;
		end else if (restart) begin
			state <= xaui_rx_pkg::DSK_WAIT_A;
		end else begin
			case (state)
				xaui_rx_pkg::DSK_IDLE: state <= xaui_rx_pkg::DSK_WAIT_A;
				xaui_rx_pkg::DSK_WAIT_A: begin
					if (release_rd) state <= xaui_rx_pkg::DSK_CHECK;
				end
				xaui_rx_pkg::DSK_CHECK: begin
					if (col_aligned && acq_cnt == `ALIGN_ACQ) begin
						state <= xaui_rx_pkg::DSK_ALIGNED;
					end
				end
				xaui_rx_pkg::DSK_ALIGNED: state <= xaui_rx_pkg::DSK_ALIGNED;
				default: state <= xaui_rx_pkg::DSK_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// first /A/ capture and skew window
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || clear) begin
			a_seen <= 4'h0;
			win_cnt <= 4'h0;
		end else if (in_wait && all_sync) begin
			a_seen <= seen_now;
			if (|a_seen) win_cnt <= 4'(win_cnt + 4'h1);
		end
	end

	// ----------------------------------------------------------------
	// deskew buffers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (we[i]) mem[i][wptr[i]] <= lw[i];
		end
	end

	// pointers are only ever cleared together, so lanes stay in step
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || clear) begin
			for (int i = 0; i < 4; i++) begin
				wptr[i] <= 4'h0;
				rptr[i] <= 4'h0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (we[i]) wptr[i] <= 4'(wptr[i] + 4'h1);
				if (rd_run) rptr[i] <= 4'(rptr[i] + 4'h1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			dsk_col <= '0;
			dsk_valid <= 1'b0;
		end else begin
			dsk_valid <= rd_run && !clear;
			for (int i = 0; i < 4; i++) begin
				dsk_col[i] <= mem[i][rptr[i]];
			end
		end
	end

	// ----------------------------------------------------------------
	// alignment acquisition and loss
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || clear) begin
			acq_cnt <= 2'h0;
			mis_cnt <= 3'h0;
		end else begin
			if (state == xaui_rx_pkg::DSK_CHECK && col_aligned &&
				acq_cnt != `ALIGN_ACQ) begin
				acq_cnt <= 2'(acq_cnt + 2'h1);
			end
			if (state == xaui_rx_pkg::DSK_ALIGNED) begin
				if (col_aligned) mis_cnt <= 3'h0;
				else if (col_mis) mis_cnt <= 3'(mis_cnt + 3'h1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || clear) begin
			lanes_aligned_o <= 1'b0;
		end else if (state == xaui_rx_pkg::DSK_CHECK && col_aligned &&
			acq_cnt == `ALIGN_ACQ) begin
			lanes_aligned_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// rate match
	// ----------------------------------------------------------------
	rate_match_fifo u_rm (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.enable_i(all_sync && lanes_aligned_o),
		.wr_valid_i(dsk_valid),
		.col_i(dsk_chr),
		.col_r_i(col_r),
		.rd_en_i(rm_rd_en_i),
		.col_o(rx_col_o),
		.col_valid_o(rx_valid_o),
		.deleted_o(rm_deleted_o),
		.inserted_o(rm_inserted_o),
		.full_o(rm_full_o),
		.empty_o(rm_empty_o)
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence all_synced_s;
		all_sync && in_wait;
	endsequence

	sequence four_seen_s;
		&seen_now && !(&a_seen);
	endsequence

	start_sync_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(rd_run) |-> $past(all_sync))
		else $error("deskew released without all lanes in sync");
	hold_ptr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(in_wait && !a_seen[0] && !a_in[0]) |=>
		wptr[0] == 4'h0 && rptr[0] == 4'h0)
		else $error("deskew pointer moved before first /A/");
	wr_run_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		all_synced_s ##0 (a_seen[1] && !clear) |=>
		wptr[1] == 4'($past(wptr[1]) + 4'h1) && rptr[1] == 4'h0)
		else $error("write pointer stalled or read moved after /A/");
	release_win_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		all_synced_s ##0 four_seen_s |=> rd_run ##1 dsk_valid && &col_a_v)
		else $error("four /A/ in window not released as one column");
	acq_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		$rose(lanes_aligned_o) |-> $past(acq_cnt) == `ALIGN_ACQ &&
		$past(col_aligned))
		else $error("alignment declared before three further columns");
	loss_count_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(lanes_aligned_o && all_sync && col_mis && mis_cnt == 3'h3) |=>
		!lanes_aligned_o && in_wait && a_seen == 4'h0)
		else $error("alignment kept after four misaligned columns");
	rm_gate_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(rm_deleted_o[0] || rm_inserted_o[0]) |-> $past(lanes_aligned_o))
		else $error("rate match acted before alignment");
endmodule

// ==== dv/xaui_tx_model.sv ====
// remote lane sender model: commas, idle stream or an injected group
`timescale 1ns/1ps
module xaui_tx_model (
	// clock
	input wire logic clk_i,
	// stream control
	input wire logic [1:0] mode_i,
	input wire xaui_rx_pkg::lane_in_t char_i,
	input wire logic comma7_i,
	input wire logic [2:0] skew3_i,
	// lanes toward the receiver
	output xaui_rx_pkg::lane_in_t [3:0] lane_o
);
	xaui_rx_pkg::lane_in_t hist [8];
	xaui_rx_pkg::lane_in_t base;
	logic [3:0] cnt;
	// ----------------------------------------------------------------
	// common stream, then per-lane skew
	// ----------------------------------------------------------------
	initial begin
		cnt = 4'h0;
		for (int i = 0; i < 8; i++) begin
			hist[i] = '0;
		end
	end
	// one base stream feeds every lane, so /R/ columns stay whole
	always_comb begin
		case (mode_i)
			2'h0: base = {8'hBC, 1'b1, 1'b0, comma7_i, 1'b1};
			2'h1: base = {(cnt == 4'h0) ? 8'h7C : 8'h1C, 4'h8};
			default: base = char_i;
		endcase
	end
	always @(negedge clk_i) begin
		cnt <= cnt + 4'h1;
		hist[0] <= base;
		for (int i = 1; i < 8; i++) begin
			hist[i] <= hist[i - 1];
		end
	end
	// skew stays under 10 cycles so deskew can always close it
	always_comb begin
		lane_o[0] = hist[0];
		lane_o[1] = hist[2];
		lane_o[2] = hist[4];
		lane_o[3] = hist[skew3_i];
	end
endmodule

// ==== dv/test_xaui_rx_deskew_rate_match.sv ====
// self-checking bench of the receive deskew and rate match block
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module test_xaui_rx_deskew_rate_match;
	logic clk_i, rst_b_i, pattern_10_i, rm_rd_en_i, comma7, rx_valid_o;
	logic lanes_aligned_o, rm_full_o, rm_empty_o;
	logic [1:0] mode;
	logic [2:0] skew3;
	logic [3:0] lane_sync_o, rm_deleted_o, rm_inserted_o;
	xaui_rx_pkg::lane_in_t chr;
	xaui_rx_pkg::lane_in_t [3:0] lanes;
	xaui_rx_pkg::column_t rx_col_o, ec;
	xaui_rx_pkg::lane_in_t ins [8];
	logic [8:0] ex [8];
	int error_cnt, checks_done, n, c;
	logic hit;
	xaui_tx_model i_xaui_tx_model (.clk_i(clk_i), .mode_i(mode),
		.char_i(chr), .comma7_i(comma7), .skew3_i(skew3), .lane_o(lanes));
	xaui_rx_deskew_rate_match i_xaui_rx_deskew_rate_match (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .lane_i(lanes), .pattern_10_i(pattern_10_i),
		.rm_rd_en_i(rm_rd_en_i), .rx_col_o(rx_col_o),
		.rx_valid_o(rx_valid_o), .lane_sync_o(lane_sync_o),
		.lanes_aligned_o(lanes_aligned_o), .rm_deleted_o(rm_deleted_o),
		.rm_inserted_o(rm_inserted_o), .rm_full_o(rm_full_o),
		.rm_empty_o(rm_empty_o));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic pick(input int w);
		case (w)
			0: return lanes_aligned_o;
			1: return |rm_deleted_o;
			2: return &lane_sync_o;
			3: return rm_full_o;
			4: return rm_empty_o;
			6: return |rm_inserted_o;
			default: return rx_valid_o;
		endcase
	endfunction
	task automatic tick(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic wait_for(input int w, input logic v, input int lim);
		n = 0;
		while (pick(w) !== v && n < lim) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task automatic count_hi(input int w, input int len);
		c = 0;
		repeat (len) begin
			@(negedge clk_i);
			if (pick(w) === 1'b1) c++;
		end
	endtask
	task automatic do_reset();
		rst_b_i <= 1'b0;
		tick(2);
		rst_b_i <= 1'b1;
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// no column may be dropped before lanes are synced and aligned
	always @(negedge clk_i) begin
		if (rst_b_i && |rm_deleted_o && !lanes_aligned_o) `CHK(1'b0, 1'b1)
	end
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		ins = '{{8'h5A, 4'h0}, {8'h9C, 4'h8}, {8'hFB, 4'h8}, {8'hFD, 4'h8},
			{8'hFE, 4'h8}, {8'h00, 4'h4}, {8'hF7, 4'h8}, {8'h1C, 4'h8}};
		ex = '{9'h05A, 9'h19C, 9'h1FB, 9'h1FD, 9'h1FE, 9'h1FE, 9'h1FE, 9'h107};
		error_cnt = 0;
		checks_done = 0;
		rst_b_i = 1'b0;
		pattern_10_i = 1'b0;
		rm_rd_en_i = 1'b0;
		mode = 2'h0;
		chr = '0;
		comma7 = 1'b0;
		skew3 = 3'h6;
		tick(12);
		`CHK({rx_valid_o, lane_sync_o, lanes_aligned_o, rm_full_o}, 7'h00)
		rst_b_i <= 1'b1;
		// drain request on an empty buffer invents nothing
		tick(1);
		rm_rd_en_i <= 1'b1;
		tick(1);
		rm_rd_en_i <= 1'b0;
		// flag rose on the edge before this sample, then two more cycles
		`CHK(rm_empty_o, 1'b1)
		count_hi(4, 4);
		`CHK(c, 2)
		count_hi(5, 4);
		`CHK(c, 0)
		do_reset();
		// only the selected comma pattern counts
		tick(12);
		`CHK(lane_sync_o, 4'h0)
		pattern_10_i <= 1'b1;
		wait_for(2, 1'b1, 20);
		`CHK(n >= 4 && n <= 7, 1'b1)
		comma7 <= 1'b1;
		// deskew and alignment with lanes skewed 0, 2, 4, 6
		rm_rd_en_i <= 1'b1;
		mode <= 2'h1;
		wait_for(0, 1'b1, 300);
		`CHK(n >= 48 && n < 300, 1'b1)
		// a drain at one column per cycle soon repeats a popped /R/ column
		wait_for(6, 1'b1, 40);
		`CHK(n < 40, 1'b1)
		`CHK(rm_inserted_o, 4'hF)
		// character mapping, one injected column each
		for (int i = 0; i < 8; i++) begin
			ec = {4{ex[i]}};
			mode <= 2'h2;
			chr <= ins[i];
			tick(1);
			mode <= 2'h1;
			hit = 1'b0;
			repeat (60) begin
				@(negedge clk_i);
				if (rx_valid_o === 1'b1 && rx_col_o === ec) hit = 1'b1;
			end
			`CHK(hit, 1'b1)
		end
		// drain stopped: /R/ columns must be deleted, never overflow
		rm_rd_en_i <= 1'b0;
		wait_for(1, 1'b1, 40);
		`CHK(n < 40, 1'b1)
		`CHK(rm_deleted_o, 4'hF)
		count_hi(3, 30);
		`CHK(c, 0)
		rm_rd_en_i <= 1'b1;
		// lane 3 slips one cycle: alignment lost, then regained
		skew3 <= 3'h7;
		wait_for(0, 1'b0, 200);
		// each /A/ period gives two misaligned columns once lane 3 slips
		`CHK(n >= 16 && n < 200, 1'b1)
		wait_for(0, 1'b1, 300);
		`CHK(n < 300, 1'b1)
		// overflow with no /R/ to delete
		rm_rd_en_i <= 1'b0;
		mode <= 2'h2;
		chr <= {8'h11, 4'h0};
		wait_for(3, 1'b1, 60);
		`CHK(n < 60, 1'b1)
		count_hi(3, 2);
		`CHK(c, 2)
		do_reset();
		tick(1);
		`CHK({rm_full_o, lanes_aligned_o}, 2'h0)
		// error counting: 3 errors healed by good groups, then 4 lose sync
		mode <= 2'h0;
		wait_for(2, 1'b1, 20);
		chr <= {8'h00, 4'h4};
		mode <= 2'h2;
		tick(3);
		mode <= 2'h1;
		tick(20);
		mode <= 2'h2;
		tick(3);
		mode <= 2'h1;
		tick(12);
		`CHK(lane_sync_o, 4'hF)
		mode <= 2'h2;
		tick(4);
		mode <= 2'h1;
		tick(12);
		`CHK(lane_sync_o, 4'h0)
		`CHK(lanes_aligned_o, 1'b0)
		wrap_up();
	end
endmodule
